// file: core/eeprom_slave_consts.svh
// Constants of the two-wire serial memory slave front end.
// Assumes inclusion by bare name from the package and the slave module.
//
// Overview of operation
// R1 - Select only when chip bits match pins
// R2 - Driven address pins settle before traffic
// R3 - Protect input high blocks writes, not reads
// R4 - Data change while clock high: Start/Stop
// R5 - Transfers begin only on idle bus
// R6 - Data fall, clock high: Start, always seen
// R7 - Data rise, clock high: Stop ends operation
// R8 - One stable bit per clock-high pulse
// R9 - Master decides byte count per transfer
// R10 - Receiver acknowledges each byte on ninth clock
// R11 - No acknowledge to launching byte while busy (code: only if byte equals the control byte that started the write)
// R12 - Acknowledge holds data low through clock high
// R13 - Unacknowledged read byte: release data line
// R14 - Control byte leads with 4-bit type code
// R15 - Block select bit acts as A15
// R16 - Two chip bits, then direction bit
// R17 - Two address bytes, high first, A15 ignored
// R18 - Acknowledge only full match, then branch
// R19 - Master makes clock and bus conditions
// R20 - Sample protect input at write Stop
// R21 - Mismatch: release line, wait for Start
`ifndef EEPROM_SLAVE_CONSTS_SVH
`define EEPROM_SLAVE_CONSTS_SVH

`define TYPE_CODE_W        4
`define TYPE_CODE_DEFAULT  4'h5
`define CTL_TYPE_MSB       7
`define CTL_TYPE_LSB       4
`define CTL_BLOCK_BIT      3
`define CTL_CS_HIGH_BIT    2
`define CTL_CS_LOW_BIT     1
`define CTL_DIR_BIT        0
`define DIR_READ           1'b1
`define ADDR_W             15
`define BIT_CNT_W          4
`define ACK_SLOT           4'h8
`define WRITE_BUSY_NS      5000000
`define CORE_CLK_MHZ       250
`define WRITE_BUSY_CYCLES  (`WRITE_BUSY_NS / 1000 * `CORE_CLK_MHZ)

`endif

// file: core/eeprom_slave_pkg.sv
// Types of the two-wire serial memory slave front end.
// Assumes the constants header is on the include path.
`include "eeprom_slave_consts.svh"

package eeprom_slave_pkg;

   typedef enum logic [2:0]
   {
      ST_IDLE     = 3'b000,
      ST_CONTROL  = 3'b001,
      ST_ADDR_HI  = 3'b010,
      ST_ADDR_LO  = 3'b011,
      ST_WR_DATA  = 3'b100,
      ST_RD_DATA  = 3'b101,
      ST_IGNORE   = 3'b110
   } phase_t;

endpackage : eeprom_slave_pkg

// file: core/eeprom_slave.sv
// Two-wire slave front end: bus conditions, control byte decode,
// word address capture, acknowledge and write-protect handling.
// Assumes serial clock and data arrive asynchronously from pins and that
// the read data byte is supplied by surrounding memory logic.
`timescale 1ns/1ps
`include "eeprom_slave_consts.svh"

module eeprom_slave #(
   parameter logic [`TYPE_CODE_W-1:0] TYPE_CODE   = `TYPE_CODE_DEFAULT, // Arbitrary value
   parameter int unsigned             BUSY_CYCLES = `WRITE_BUSY_CYCLES
)
(
   input  wire logic                core_clk,
   input  wire logic                reset_n,
   input  wire logic                scl_in,
   input  wire logic                sda_in,
   output logic                     sda_out,
   output logic                     sda_oe,
   input  wire logic                chip_select_pin_low,
   input  wire logic                chip_select_pin_high,
   input  wire logic                write_protect,
   input  wire logic [7:0]          read_data,
   output logic [`ADDR_W-1:0]       word_addr,
   output logic                     block_select_bit,
   output logic                     wr_data_valid,
   output logic [7:0]               wr_data,
   output logic                     rd_data_req,
   output logic                     write_start,
   output logic                     write_busy,
   output logic                     selected
);

   // --------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic [1:0] cs_sync_q [2];
   logic [1:0] wp_sync_q;
   logic       scl_q;
   logic       sda_q;

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         scl_sync_q   <= 2'h3;
         sda_sync_q   <= 2'h3;
         cs_sync_q[0] <= 2'h0;
         cs_sync_q[1] <= 2'h0;
         wp_sync_q    <= 2'h3;
         scl_q        <= 1'b1;
         sda_q        <= 1'b1;
      end
      else
      begin
         scl_sync_q   <= {scl_sync_q[0], scl_in};
         sda_sync_q   <= {sda_sync_q[0], sda_in};
         cs_sync_q[0] <= {cs_sync_q[0][0], chip_select_pin_low};
         cs_sync_q[1] <= {cs_sync_q[1][0], chip_select_pin_high};
         wp_sync_q    <= {wp_sync_q[0], write_protect};
         scl_q        <= scl_sync_q[1];
         sda_q        <= sda_sync_q[1];
      end
   end

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_s     = scl_sync_q[1];
   assign sda_s     = sda_sync_q[1];
   assign scl_rise  = scl_s & ~scl_q;
   assign scl_fall  = ~scl_s & scl_q;
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;   // R4 R6
   assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;   // R4 R7

   // --------------------------------------------------------------
   // Bus activity and bit counter
   // --------------------------------------------------------------
   eeprom_slave_pkg::phase_t phase_q;
   logic [`BIT_CNT_W-1:0]    bit_cnt_q;
   logic [7:0]               shift_q;
   logic [7:0]               tx_q;
   logic                     ack_q;
   logic                     master_nack_q;
   logic                     in_ack;
   logic                     drive_upd_q;

   assign in_ack = (bit_cnt_q == `ACK_SLOT);

   // Start reframes mid-transfer; all ones skips the fall that ends Start
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         bit_cnt_q <= 4'h0;
      else if (start_det || stop_det)                   // R6
         bit_cnt_q <= 4'hf;
      else if (scl_fall)
         bit_cnt_q <= in_ack ? 4'h0 : bit_cnt_q + 4'h1; // R10
   end

   // Sample data on clock rise, one bit per pulse
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         shift_q <= 8'h00;
      else if (scl_rise && !in_ack)
         shift_q <= {shift_q[6:0], sda_s};              // R8
   end

   // --------------------------------------------------------------
   // Control byte decode
   // --------------------------------------------------------------
   function automatic logic ctl_match(input logic [7:0] b, input logic cs_lo, input logic cs_hi);
      ctl_match = (b[`CTL_TYPE_MSB:`CTL_TYPE_LSB] == TYPE_CODE) && // R14
                  (b[`CTL_CS_HIGH_BIT] == cs_hi) &&
                  (b[`CTL_CS_LOW_BIT] == cs_lo);                   // R1 R16
   endfunction : ctl_match

   logic       byte_done;
   logic       match;
   logic [7:0] busy_ctl_q;
   logic [7:0] last_ctl_q;
   logic       wr_pending_q;
   logic       busy_block;

   assign byte_done  = scl_fall && (bit_cnt_q == 4'h7);
   assign match      = ctl_match(shift_q, cs_sync_q[0][1], cs_sync_q[1][1]);
   assign busy_block = write_busy && (shift_q == busy_ctl_q);  // R11

   // --------------------------------------------------------------
   // Transfer phase
   // --------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         phase_q <= eeprom_slave_pkg::ST_IDLE;
      else if (start_det)                               // R5 R6
         phase_q <= eeprom_slave_pkg::ST_CONTROL;
      else if (stop_det)                                // R7
         phase_q <= eeprom_slave_pkg::ST_IDLE;
      else if (scl_fall && in_ack)
      begin
         case (phase_q)
            eeprom_slave_pkg::ST_CONTROL:
               if (!ack_q)
                  phase_q <= eeprom_slave_pkg::ST_IGNORE;     // R21
               else if (last_ctl_q[`CTL_DIR_BIT] == `DIR_READ)
                  phase_q <= eeprom_slave_pkg::ST_RD_DATA;    // R18
               else
                  phase_q <= eeprom_slave_pkg::ST_ADDR_HI;    // R17
            eeprom_slave_pkg::ST_ADDR_HI:
               phase_q <= eeprom_slave_pkg::ST_ADDR_LO;
            eeprom_slave_pkg::ST_ADDR_LO:
               phase_q <= eeprom_slave_pkg::ST_WR_DATA;
            eeprom_slave_pkg::ST_RD_DATA:
               if (master_nack_q)
                  phase_q <= eeprom_slave_pkg::ST_IGNORE;     // R13
            default:
               phase_q <= phase_q;
         endcase
      end
   end

   // Acknowledge decision and captured fields
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         ack_q            <= 1'b0;
         last_ctl_q       <= 8'h00;
         word_addr        <= 15'h0000;
         block_select_bit <= 1'b0;
         selected         <= 1'b0;
      end
      else if (start_det || stop_det)
      begin
         ack_q    <= 1'b0;
         selected <= 1'b0;
      end
      else if (byte_done)
      begin
         case (phase_q)
            eeprom_slave_pkg::ST_CONTROL:
            begin
               ack_q      <= match && !busy_block;       // R18 R11
               selected   <= match && !busy_block;
               last_ctl_q <= shift_q;
               if (match && !busy_block)
                  block_select_bit <= shift_q[`CTL_BLOCK_BIT]; // R15
            end
            eeprom_slave_pkg::ST_ADDR_HI:
            begin
               ack_q                    <= 1'b1;
               word_addr[`ADDR_W-1:8]   <= shift_q[6:0];   // R17
            end
            eeprom_slave_pkg::ST_ADDR_LO:
            begin
               ack_q          <= 1'b1;
               word_addr[7:0] <= shift_q;
            end
            eeprom_slave_pkg::ST_WR_DATA:
            begin
               ack_q     <= 1'b1;                        // R10
               word_addr <= word_addr + 15'h0001;
            end
            default:
               ack_q <= 1'b0;
         endcase
      end
      else if (scl_fall && in_ack)
         ack_q <= 1'b0;
   end

   // --------------------------------------------------------------
   // Read data path and master acknowledge
   // --------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         tx_q          <= 8'hff;
         master_nack_q <= 1'b0;
         rd_data_req   <= 1'b0;
         drive_upd_q   <= 1'b0;
      end
      else
      begin
         drive_upd_q <= scl_fall;
         rd_data_req <= scl_fall && in_ack &&
                        ((phase_q == eeprom_slave_pkg::ST_CONTROL && ack_q &&
                          last_ctl_q[`CTL_DIR_BIT] == `DIR_READ) ||
                         (phase_q == eeprom_slave_pkg::ST_RD_DATA && !master_nack_q));
         if (rd_data_req)
            tx_q <= read_data;
         else if (scl_fall && phase_q == eeprom_slave_pkg::ST_RD_DATA && !in_ack)
            tx_q <= {tx_q[6:0], 1'b1};
         if (scl_rise && in_ack)
            master_nack_q <= sda_s;                      // R13
      end
   end

   // --------------------------------------------------------------
   // Data line drive
   // --------------------------------------------------------------
   // Drive changes one cycle after the synchronised clock fall, once count
   // and ack have settled, so the line stays steady while the clock is high.
   logic drive_low_d;

   always_comb
   begin
      drive_low_d = 1'b0;
      if (phase_q == eeprom_slave_pkg::ST_RD_DATA && !in_ack)
         drive_low_d = rd_data_req ? ~read_data[7] : ~tx_q[7];
      else if (in_ack && ack_q)
         drive_low_d = 1'b1;                             // R12
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         sda_out <= 1'b1;
         sda_oe  <= 1'b0;
      end
      else if (start_det || stop_det)
      begin
         sda_out <= 1'b1;
         sda_oe  <= 1'b0;                                // R21
      end
      else if (drive_upd_q)
      begin
         sda_out <= 1'b0;
         sda_oe  <= drive_low_d;
      end
   end

   // --------------------------------------------------------------
   // Write data, protect sample and busy timer
   // --------------------------------------------------------------
   logic [31:0] busy_cnt_q;

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         wr_data_valid <= 1'b0;
         wr_data       <= 8'h00;
         wr_pending_q  <= 1'b0;
      end
      else
      begin
         wr_data_valid <= byte_done && phase_q == eeprom_slave_pkg::ST_WR_DATA;
         if (byte_done && phase_q == eeprom_slave_pkg::ST_WR_DATA)
         begin
            wr_data      <= shift_q;
            wr_pending_q <= 1'b1;
         end
         else if (start_det || stop_det)
            wr_pending_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         write_start <= 1'b0;
         write_busy  <= 1'b0;
         busy_cnt_q  <= 32'h0;
         busy_ctl_q  <= 8'h00;
      end
      else
      begin
         write_start <= 1'b0;
         if (stop_det && wr_pending_q && !wp_sync_q[1])  // R3 R20
         begin
            write_start <= 1'b1;
            write_busy  <= 1'b1;
            busy_cnt_q  <= 32'(BUSY_CYCLES);
            busy_ctl_q  <= last_ctl_q;
         end
         else if (write_busy)
         begin
            if (busy_cnt_q <= 32'h1)
               write_busy <= 1'b0;
            busy_cnt_q <= busy_cnt_q - 32'h1;
         end
      end
   end

endmodule : eeprom_slave

// file: test/eeprom_slave_props.sv
// Concurrent checks on the two-wire slave front end.
// Assumes binding to eeprom_slave and sight of its ports only.
`timescale 1ns/1ps
module eeprom_slave_props #(
   parameter int unsigned BUSY_CYCLES = 50
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic wr_data_valid,
   input wire logic rd_data_req,
   input wire logic write_start,
   input wire logic write_busy,
   input wire logic selected
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   logic [31:0] busy_q;

   // Counts consecutive busy cycles
   always_ff @(posedge core_clk)
   begin
      busy_q <= (!reset_n || !write_busy) ? 32'h0 : busy_q + 32'h1;
   end

   sequence scl_held;
      scl_in ##1 scl_in ##1 scl_in;
   endsequence

   a_ack_pulls_low: assert property (sda_oe |-> !sda_out)
      else $error("data driven high");
   a_steady_high: assert property (scl_held |-> $stable(sda_oe))
      else $error("data drive changed while clock high");
   a_start_sets_busy: assert property (write_start |=> write_busy [*8])
      else $error("busy missing after write start");
   a_busy_cause: assert property ($rose(write_busy) |-> write_start)
      else $error("busy without write start");
   a_busy_length: assert property ($fell(write_busy) |-> busy_q == BUSY_CYCLES)
      else $error("busy length wrong");
   a_write_selected: assert property (wr_data_valid |-> selected)
      else $error("write byte while unselected");
   a_read_selected: assert property (rd_data_req |-> selected)
      else $error("read request while unselected");
   a_drive_bounded: assert property ($rose(sda_oe) |-> ##[1:100] !sda_oe)
      else $error("data line never released");
   a_pulse_single: assert property (write_start |=> !write_start)
      else $error("write start longer than one cycle");
endmodule : eeprom_slave_props

bind eeprom_slave eeprom_slave_props #(.BUSY_CYCLES(BUSY_CYCLES)) props
(
   .core_clk(core_clk),
   .reset_n(reset_n),
   .scl_in(scl_in),
   .sda_out(sda_out),
   .sda_oe(sda_oe),
   .wr_data_valid(wr_data_valid),
   .rd_data_req(rd_data_req),
   .write_start(write_start),
   .write_busy(write_busy),
   .selected(selected)
);

// file: test/bus_master_model.sv
// Behavioural two-wire bus master with a pulled-up data line.
// Assumes the slave pulls data low while its output enable is high.
`timescale 1ns/1ps
module bus_master_model
(
   input  wire logic core_clk,
   output logic scl,
   output logic sda,
   input  wire logic sda_oe
);
   logic sda_m;

   assign sda = sda_m & ~sda_oe;

   initial
   begin
      scl = 1'b1;
      sda_m = 1'b1;
   end

   // One clock pulse of 32 ns; data moves only while clock is low
   task automatic clk_bit(input logic b, output logic r);
      sda_m = b;
      #8 scl = 1'b1;
      #8 r = sda;
      #8 scl = 1'b0;
      #8;
   endtask : clk_bit

   // Steps off the core clock edge so pin changes never race its sampling
   task automatic start_c;
      @(posedge core_clk);
      #1 sda_m = 1'b1;
      #8 scl = 1'b1;
      #8 sda_m = 1'b0;
      #8 scl = 1'b0;
      #8;
   endtask : start_c

   task automatic stop_c;
      sda_m = 1'b0;
      #8 scl = 1'b1;
      #8 sda_m = 1'b1;
      #16;
   endtask : stop_c

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
         clk_bit(b[i], ack);
      clk_bit(1'b1, ack);
   endtask : wr_byte

   task automatic rd_byte(output logic [7:0] b, input logic nack);
      logic r;
      for (int i = 7; i >= 0; i--)
         clk_bit(1'b1, b[i]);
      clk_bit(nack, r);
   endtask : rd_byte
endmodule : bus_master_model

// file: test/eeprom_slave_bench.sv
// Self-checking bench for the two-wire slave front end.
// Assumes the master model and bound checker are compiled alongside.
`timescale 1ns/1ps
module eeprom_slave_bench;
   logic        core_clk, reset_n, scl_in, sda_in, sda_out, sda_oe;
   logic        chip_select_pin_low, chip_select_pin_high, write_protect;
   logic [7:0]  read_data, wr_data, got;
   logic [14:0] word_addr;
   logic        block_select_bit, wr_data_valid, rd_data_req;
   logic        write_start, write_busy, selected, ack;
   logic [7:0]  bad [3] = '{8'h68, 8'h6e, 8'h2a};
   int          n_mismatch = 0;
   int          checks = 0;
   int          n_start = 0;

   eeprom_slave #(.TYPE_CODE(4'h6), .BUSY_CYCLES(300)) DUT
   (
      .core_clk(core_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pin_low(chip_select_pin_low),
      .chip_select_pin_high(chip_select_pin_high), .write_protect(write_protect),
      .read_data(read_data), .word_addr(word_addr), .block_select_bit(block_select_bit),
      .wr_data_valid(wr_data_valid), .wr_data(wr_data), .rd_data_req(rd_data_req),
      .write_start(write_start), .write_busy(write_busy), .selected(selected)
   );

   bus_master_model m (.core_clk(core_clk), .scl(scl_in), .sda(sda_in), .sda_oe(sda_oe));

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      if (write_start === 1'b1)
         n_start++;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done

   task automatic send(input logic [7:0] b, input logic exp_ack);
      m.wr_byte(b, ack);
      check(ack, exp_ack);
   endtask : send

   task automatic wait_ready;
      for (int i = 0; i < 200 && write_busy !== 1'b0; i++)
         @(negedge core_clk);
      if (write_busy !== 1'b0)
      begin
         n_mismatch++;
         test_done;
      end
   endtask : wait_ready

   initial
   begin
      #100000;
      n_mismatch++;
      test_done;
   end

   initial
   begin
      reset_n = 1'b0;
      write_protect = 1'b0;
      read_data = 8'h96;
      chip_select_pin_low = 1'b1;
      chip_select_pin_high = 1'b0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      // Byte write, protect raised after the Stop
      m.start_c;
      send(8'h6a, 1'b0);
      send(8'hc3, 1'b0);
      send(8'h5a, 1'b0);
      check(word_addr, 16'h435a);
      check(block_select_bit, 1'b1);
      send(8'h3c, 1'b0);
      check(wr_data, 8'h3c);
      check(word_addr, 16'h435b);
      m.stop_c;
      repeat (10) @(posedge core_clk);
      write_protect <= 1'b1;
      repeat (4) @(posedge core_clk);
      check(write_busy, 1'b1);
      // Polling while busy, then a read by repeated Start
      m.start_c;
      send(8'h6a, 1'b1);
      send(8'h00, 1'b1);
      m.start_c;
      send(8'h6b, 1'b0);
      m.rd_byte(got, 1'b1);
      check(got, 8'h96);
      m.stop_c;
      wait_ready;
      // Foreign type code or chip bits
      foreach (bad[i])
      begin
         m.start_c;
         send(bad[i], 1'b1);
         m.stop_c;
      end
      // Protected write is acknowledged but never launched
      m.start_c;
      send(8'h6a, 1'b0);
      send(8'h01, 1'b0);
      send(8'h02, 1'b0);
      send(8'h55, 1'b0);
      m.stop_c;
      repeat (20) @(posedge core_clk);
      check(write_busy, 1'b0);
      write_protect <= 1'b0;
      // Address-only write starts no cycle
      m.start_c;
      send(8'h6a, 1'b0);
      send(8'h00, 1'b0);
      send(8'h10, 1'b0);
      m.stop_c;
      repeat (20) @(posedge core_clk);
      check(16'(n_start), 16'h0001);
      test_done;
   end
endmodule : eeprom_slave_bench
